// ===== design/bsram_map.vh
// Constants for the burst SRAM synchronous port
`ifndef BSRAM_MAP_VH
`define BSRAM_MAP_VH
// Word width of one data beat (36-bit variant)
`define BSRAM_DATA_W      36
// Width of one masked lane
`define BSRAM_LANE_W      9
// Number of byte lanes in the 36-bit variant
`define BSRAM_LANES       4
// Nibble variant: word width and nibble width
`define BSRAM_NIB_DATA_W  8
`define BSRAM_NIB_W       4
// Address width: depth of each internal array
`define BSRAM_ADDR_W      8
// Read latency in strobe periods
`define BSRAM_RD_LAT      2
// Write data FIFO depth in command entries
`define BSRAM_FIFO_DEPTH  16
// Access direction encodings
`define BSRAM_DIR_READ    1'b1
`define BSRAM_DIR_WRITE   1'b0
`endif

// ===== design/bsram_fifo.v
// Parameterised valid/ready FIFO used in the write data path
`timescale 1ns/1ps
module bsram_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys_i,
    input  wire             reset_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output reg  [WIDTH-1:0] out_data_o,
    output reg              out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_ff;
    reg [AW:0]      rd_ptr_ff;
    wire            full;
    wire            empty;
    wire            pop;

    assign full       = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) &&
                        (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    assign empty      = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready_o = ~full;
    // Refill output register when empty or consumed
    assign pop        = ~empty && (~out_valid_o || out_ready_i);

    // ========================================
    // Storage and pointers
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_ptr_ff   <= {(AW+1){1'b0}};
            rd_ptr_ff   <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            if (in_valid_i && ~full) begin
                mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                out_data_o  <= mem[rd_ptr_ff[AW-1:0]];
                rd_ptr_ff   <= rd_ptr_ff + 1'b1;
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

// ===== design/bsram_port.v
// Synchronous two-beat burst DDR SRAM port, device side
`timescale 1ns/1ps
`include "bsram_map.vh"
// ========================================
// Overview of operation
// [RULE1] Nibble selects mask bits 3:0 and 7:4
// [RULE2] Nibble masks sampled with their data beat
// [RULE3] Deasserted nibble mask keeps stored nibble
// [RULE4] Lane masks cover 9-bit lanes 0 to 3
// [RULE5] Lane masks sampled with their data beat
// [RULE6] Deasserted lane mask keeps stored lane
// [RULE7] Address captured on true strobe rise
// [RULE8] Address ignored when no access selected
// [RULE9] Storage is two half-depth word arrays
// [RULE10] Direction high reads, low writes when loaded
// [RULE11] Read valid marks beats, aligned to echo
// [RULE12] Accesses start only on true strobe rise
// [RULE13] Both strobe rises capture and launch beats
// [RULE14] Echo strobes toggle freely, follow true strobe
// [RULE15] Host loads each two-word burst transaction
// [RULE16] Data drivers off unless read serviced
// [RULE17] First read beat after fixed latency
// [RULE18] Beat one uses array one, beat two array two
// ========================================
// Timing notes
// Strobe pins and all sampled pins share a two-flop delay,
// so a pin value and the strobe edge that qualifies it
// reach the sequencer in the same system clock.
// An edge is acted on about three clocks after the pin.
// The strobe half period must exceed one system clock;
// a faster strobe merges edges and beats are lost.
// Multi-bit buses cross with plain two-flop stages.
// That is safe only because the host holds each beat
// steady for several clocks after its strobe edge.
//
// ========================================
// Write path
// Beat one is taken on the load edge itself,
// beat two on the next complement strobe rise.
// Both beats queue in the write FIFO with their masks;
// the arrays update a few clocks later, off the pins.
// A load seen while beat two is pending is dropped.
// Writes are lost if the FIFO fills; with one burst
// at a time and a drain every clock it cannot fill.
// The drain stalls for one clock while a read fetches,
// so a fetch never races a merge into the same word.
// A stalled head word is never counted as written.
//
// ========================================
// Read path
// A read load arms a counter of true strobe rises.
// The fetch reads both arrays at once; beat one goes
// straight out, beat two waits in a holding register.
// Beat two leaves on the next complement strobe rise.
// Output enable and valid fall at the true rise after it,
// so the pair stands for one full strobe period.
// Loads during the latency wait are ignored.
// A write queued just before a read of the same address
// lands before the fetch: the wait far exceeds the drain.
//
// ========================================
// Echo path
// The echo pair copies the synchronised true strobe.
// It runs whether or not an access is in flight,
// and lags the pin by three system clocks.
// Valid and data line up with an echo edge only to
// within one system clock.
//
// ========================================
// Reset
// Reset clears the sequencer, the FIFO and the outputs.
// Storage keeps its contents and is never cleared;
// words not yet written read back as unknown.
// Synchronisers are not reset; they flush in two clocks.
//
// ========================================
// Limitations
// One burst at a time; back-to-back loads are not pipelined.
// The strobe pair must be supplied at all times.
// The nibble variant uses mask lanes zero and one only;
// the byte lane inputs are ignored there.
// Array depth is set by ADDR_W and kept small on purpose.
module bsram_port #(
    parameter DATA_W   = `BSRAM_DATA_W,
    parameter LANE_W   = `BSRAM_LANE_W,
    parameter LANES    = `BSRAM_LANES,
    parameter ADDR_W   = `BSRAM_ADDR_W,
    parameter RD_LAT   = `BSRAM_RD_LAT,
    parameter NIBBLE   = 0,
    parameter FIFO_D   = `BSRAM_FIFO_DEPTH
) (
    input  wire              clk_sys_i,
    input  wire              reset_i,
    input  wire              strobe_k_i,
    input  wire              strobe_k_n_i,
    input  wire              cycle_define_n_i,
    input  wire              access_direction_i,
    input  wire [ADDR_W-1:0] addr_i,
    input  wire [DATA_W-1:0] data_i,
    input  wire [LANES-1:0]  byte_write_lane_n_i,
    input  wire [1:0]        nibble_write_select_n_i,
    output reg  [DATA_W-1:0] data_o,
    output reg               data_oe_o,
    output reg               echo_strobe_o,
    output reg               echo_strobe_n_o,
    output reg               read_output_valid_o
);
    localparam MASK_W = LANES;
    localparam CMD_W  = ADDR_W + 1 + MASK_W + DATA_W;
    localparam ST_IDLE  = 2'b00;
    localparam ST_WBEAT = 2'b01;
    localparam ST_RWAIT = 2'b10;
    localparam LAT_W    = 4;

    // ========================================
    // Pin synchronisers
    reg [1:0] k_sync_ff;
    reg [1:0] kn_sync_ff;
    reg [1:0] ld_sync_ff;
    reg [1:0] dir_sync_ff;
    reg [ADDR_W-1:0] a_meta_ff;
    reg [ADDR_W-1:0] a_sync_ff;
    reg [DATA_W-1:0] d_meta_ff;
    reg [DATA_W-1:0] d_sync_ff;
    reg [LANES-1:0]  bw_meta_ff;
    reg [LANES-1:0]  bw_sync_ff;
    reg [1:0]        nw_meta_ff;
    reg [1:0]        nw_sync_ff;
    reg              k_last_ff;
    reg              kn_last_ff;

    // Two flops ahead of any logic; only stage two is read
    always @(posedge clk_sys_i) begin
        k_sync_ff   <= {k_sync_ff[0], strobe_k_i};
        kn_sync_ff  <= {kn_sync_ff[0], strobe_k_n_i};
        ld_sync_ff  <= {ld_sync_ff[0], cycle_define_n_i};
        dir_sync_ff <= {dir_sync_ff[0], access_direction_i};
        a_meta_ff   <= addr_i;
        a_sync_ff   <= a_meta_ff;
        d_meta_ff   <= data_i;
        d_sync_ff   <= d_meta_ff;
        bw_meta_ff  <= byte_write_lane_n_i;
        bw_sync_ff  <= bw_meta_ff;
        nw_meta_ff  <= nibble_write_select_n_i;
        nw_sync_ff  <= nw_meta_ff;
        k_last_ff   <= k_sync_ff[1];
        kn_last_ff  <= kn_sync_ff[1];
    end

    wire k_rise  = k_sync_ff[1] & ~k_last_ff;
    wire kn_rise = kn_sync_ff[1] & ~kn_last_ff;
    wire beat_en = k_rise | kn_rise;                          // [RULE13]

    // Active-high per-lane write enable for the current beat
    function [MASK_W-1:0] lane_enable;
        input [LANES-1:0] bw_n;
        input [1:0]       nw_n;
        begin
            if (NIBBLE != 0)
                lane_enable = {{(MASK_W-2){1'b0}}, ~nw_n};    // [RULE1]
            else
                lane_enable = ~bw_n;                          // [RULE4]
        end
    endfunction

    // Bit-level mask built from lane enables
    function [DATA_W-1:0] bit_mask;
        input [MASK_W-1:0] en;
        integer i;
        begin
            bit_mask = {DATA_W{1'b0}};
            for (i = 0; i < DATA_W; i = i + 1) begin
                if (NIBBLE != 0)
                    bit_mask[i] = (i < 8) ? en[i/4] : 1'b0;   // [RULE1]
                else
                    bit_mask[i] = en[i/LANE_W];               // [RULE4]
            end
        end
    endfunction

    // ========================================
    // Access sequencer
    reg [1:0]        state_ff;
    reg [1:0]        nxt_state;
    reg [ADDR_W-1:0] addr_ff;
    reg [ADDR_W-1:0] nxt_addr;
    reg [LAT_W-1:0]  lat_ff;
    reg [LAT_W-1:0]  nxt_lat;
    reg              push;
    reg [DATA_W-1:0] push_data;
    reg [MASK_W-1:0] push_mask;
    reg              push_beat;
    reg              rd_start;
    wire             fifo_rdy;
    wire             load = k_rise & ~ld_sync_ff[1];          // [RULE12] [RULE15]

    always @* begin
        nxt_state = state_ff;
        nxt_addr  = addr_ff;
        nxt_lat   = lat_ff;
        push      = 1'b0;
        push_data = d_sync_ff;
        push_mask = lane_enable(bw_sync_ff, nw_sync_ff);      // [RULE2] [RULE5]
        push_beat = 1'b0;
        rd_start  = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Address only latched on a load; ignored otherwise
                if (load) begin
                    nxt_addr = a_sync_ff;                     // [RULE7] [RULE8]
                    if (dir_sync_ff[1] == `BSRAM_DIR_READ) begin  // [RULE10]
                        nxt_state = ST_RWAIT;
                        nxt_lat   = RD_LAT[LAT_W-1:0];
                    end else begin
                        // First write beat rides the same true strobe edge
                        push      = 1'b1;
                        push_beat = 1'b0;                     // [RULE18]
                        nxt_state = ST_WBEAT;
                    end
                end
            end
            ST_WBEAT: begin
                if (kn_rise) begin
                    push      = 1'b1;
                    push_beat = 1'b1;                         // [RULE18]
                    nxt_state = ST_IDLE;
                end
            end
            ST_RWAIT: begin
                if (k_rise) begin
                    if (lat_ff == {{(LAT_W-1){1'b0}}, 1'b1}) begin
                        rd_start  = 1'b1;                     // [RULE17]
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_lat = lat_ff - 1'b1;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            addr_ff  <= {ADDR_W{1'b0}};
            lat_ff   <= {LAT_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            addr_ff  <= nxt_addr;
            lat_ff   <= nxt_lat;
        end
    end

    // ========================================
    // Write data FIFO: decouples beat capture from array update
    wire [CMD_W-1:0] fifo_out;
    wire             fifo_valid;
    wire             wr_addr_sel = push_beat;
    wire [ADDR_W-1:0] push_addr  = (state_ff == ST_IDLE) ? a_sync_ff : addr_ff;
    // Array ports are free except during a read fetch
    wire             drain_rdy   = ~rd_start;

    bsram_fifo #(
        .WIDTH (CMD_W + 0),
        .DEPTH (FIFO_D),
        .AW    (4)
    ) u_wfifo (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_data_i   ({push_addr, wr_addr_sel, push_mask, push_data}),
        .in_valid_i  (push & fifo_rdy),
        .in_ready_o  (fifo_rdy),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (drain_rdy)
    );

    // ========================================
    // Two half-depth arrays, one per burst beat
    reg [DATA_W-1:0] array0 [0:(1<<ADDR_W)-1];                // [RULE9]
    reg [DATA_W-1:0] array1 [0:(1<<ADDR_W)-1];                // [RULE9]
    wire [ADDR_W-1:0] w_addr = fifo_out[CMD_W-1 -: ADDR_W];
    wire              w_beat = fifo_out[MASK_W+DATA_W];
    wire [MASK_W-1:0] w_en   = fifo_out[DATA_W +: MASK_W];
    wire [DATA_W-1:0] w_data = fifo_out[DATA_W-1:0];
    wire [DATA_W-1:0] w_msk  = bit_mask(w_en);
    // Must match the FIFO's own pop test, or a word is dropped
    wire              w_go   = fifo_valid & drain_rdy;

    // Masked merge; unselected lanes keep their old contents
    always @(posedge clk_sys_i) begin
        if (w_go) begin
            if (w_beat)
                array1[w_addr] <= (array1[w_addr] & ~w_msk) | (w_data & w_msk); // [RULE3] [RULE6]
            else
                array0[w_addr] <= (array0[w_addr] & ~w_msk) | (w_data & w_msk); // [RULE3] [RULE6]
        end
    end

    // ========================================
    // Read launch: beat one on true rise, beat two on complement rise
    reg [DATA_W-1:0] rd_b1_ff;
    reg              rd_pend_ff;

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            data_o              <= {DATA_W{1'b0}};
            data_oe_o           <= 1'b0;
            read_output_valid_o <= 1'b0;
            rd_b1_ff            <= {DATA_W{1'b0}};
            rd_pend_ff          <= 1'b0;
        end else begin
            if (rd_start) begin
                data_o              <= array0[addr_ff];       // [RULE18]
                rd_b1_ff            <= array1[addr_ff];       // [RULE18]
                data_oe_o           <= 1'b1;                  // [RULE16]
                read_output_valid_o <= 1'b1;                  // [RULE11]
                rd_pend_ff          <= 1'b1;
            end else if (kn_rise && rd_pend_ff) begin
                data_o     <= rd_b1_ff;                       // [RULE13] [RULE17]
                rd_pend_ff <= 1'b0;
            end else if (k_rise && !rd_pend_ff) begin
                // Burst done at next true edge: release the bus
                data_oe_o           <= 1'b0;                  // [RULE16]
                read_output_valid_o <= 1'b0;                  // [RULE11]
            end
        end
    end

    // ========================================
    // Echo strobes follow the sampled true strobe, always running
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            echo_strobe_o   <= 1'b0;
            echo_strobe_n_o <= 1'b1;
        end else begin
            echo_strobe_o   <= k_sync_ff[1];                  // [RULE14]
            echo_strobe_n_o <= ~k_sync_ff[1];                 // [RULE14]
        end
    end
endmodule

// ===== bench/bsram_port_props.sv
// Concurrent checks on the burst SRAM port pins
`timescale 1ns/1ps
module bsram_port_props #(
    parameter RD_LAT = 2
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire strobe_k_i,
    input wire cycle_define_n_i,
    input wire access_direction_i,
    input wire data_oe_o,
    input wire echo_strobe_o,
    input wire echo_strobe_n_o,
    input wire read_output_valid_o
);
    // ========================================
    // Timing windows
    // Bounds assume a strobe period of eight system clocks
    localparam int LAT_LO = 8 * RD_LAT + 1;
    localparam int LAT_HI = 8 * RD_LAT + 7;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // Load phases seen at the true strobe pin
    sequence s_rd_load;
        $rose(strobe_k_i) && !cycle_define_n_i && access_direction_i && !data_oe_o;
    endsequence
    sequence s_wr_load;
        $rose(strobe_k_i) && !cycle_define_n_i && !access_direction_i && !data_oe_o;
    endsequence
    sequence s_burst;
        read_output_valid_o [*6] ##[1:4] !read_output_valid_o;
    endsequence
    // ========================================
    // Assertions
    chk_echo_pair: assert property (echo_strobe_o != echo_strobe_n_o)
        else $error("echo pair not complementary");
    chk_echo_runs: assert property (1'b1 |-> ##[0:10] $changed(echo_strobe_o))
        else $error("echo strobe stopped");
    chk_echo_follow: assert property ($rose(strobe_k_i) |-> ##[2:5] echo_strobe_o)
        else $error("echo not following true strobe");
    chk_valid_oe: assert property (read_output_valid_o == data_oe_o)
        else $error("valid and output enable disagree");
    chk_valid_edge: assert property ($changed(read_output_valid_o) |-> ##[0:2] echo_strobe_o)
        else $error("valid edge off the echo edge");
    chk_read_burst: assert property ($rose(read_output_valid_o) |-> s_burst)
        else $error("read burst length wrong");
    chk_read_latency: assert property (s_rd_load |-> ##[LAT_LO:LAT_HI] $rose(read_output_valid_o))
        else $error("read latency wrong");
    chk_write_quiet: assert property (s_wr_load |-> ##1 !data_oe_o [*8])
        else $error("outputs driven during write");
endmodule

bind bsram_port bsram_port_props #(.RD_LAT(RD_LAT)) u_props (
    .clk_sys_i          (clk_sys_i),
    .reset_i            (reset_i),
    .strobe_k_i         (strobe_k_i),
    .cycle_define_n_i   (cycle_define_n_i),
    .access_direction_i (access_direction_i),
    .data_oe_o          (data_oe_o),
    .echo_strobe_o      (echo_strobe_o),
    .echo_strobe_n_o    (echo_strobe_n_o),
    .read_output_valid_o(read_output_valid_o)
);

// ===== bench/bsram_host_model.sv
// Host memory controller model driving the burst SRAM pins
`timescale 1ns/1ps
module bsram_host_model (
    input  wire        clk_sys_i,
    output wire        strobe_k_o,
    output wire        strobe_k_n_o,
    output reg         cycle_define_n_o,
    output reg         access_direction_o,
    output reg  [7:0]  addr_o,
    output reg  [35:0] data_o,
    output reg  [3:0]  lane_n_o
);
    reg [2:0] ph_ff = 3'h0;
    // ========================================
    // Free running strobe pair, eight system clocks a period
    always @(negedge clk_sys_i) ph_ff <= ph_ff + 3'h1;
    assign strobe_k_o   = (ph_ff < 3'h4);
    assign strobe_k_n_o = ~strobe_k_o;
    // Idle pin levels at time zero
    initial begin
        cycle_define_n_o   = 1'b1;
        access_direction_o = 1'b0;
        addr_o             = 8'h00;
        data_o             = 36'h0;
        lane_n_o           = 4'hf;
    end
    // Waits for the clock before the given phase ends
    task wait_ph(input [2:0] p);
        begin
            @(negedge clk_sys_i);
            while (ph_ff != p) @(negedge clk_sys_i);
        end
    endtask
    // One two-beat burst; beats change on strobe pin edges for full margin
    task xfer(input dir, input [7:0] a, input [35:0] d0, d1, input [3:0] m0, m1);
        begin
            wait_ph(3'h7);
            cycle_define_n_o   = 1'b0;
            access_direction_o = dir;
            addr_o             = a;
            data_o             = d0;
            lane_n_o           = m0;
            wait_ph(3'h3);
            cycle_define_n_o   = 1'b1;
            access_direction_o = ~dir;
            addr_o             = ~a; // Deselected half carries a foreign address
            data_o             = d1;
            lane_n_o           = m1;
            wait_ph(3'h7);
            data_o             = ~d1; // Released lines never hold the last beat
            lane_n_o           = 4'hf;
        end
    endtask
endmodule

// ===== bench/test_burst_sram_sync_port.sv
// Self-checking testbench for the burst SRAM synchronous port
`timescale 1ns/1ps
module test_burst_sram_sync_port;
    reg         clk_sys_i = 1'b0;
    reg         reset_i   = 1'b1;
    wire        k, k_n, ld_n, dir, oe, echo, echo_n, vld;
    wire [7:0]  addr, nib_dout;
    wire [35:0] din, dout;
    wire [3:0]  lane_n;
    integer     n_fail    = 0;
    integer     tests_run = 0;
    // ========================================
    // Clock, partner and both width variants
    always #50 clk_sys_i = ~clk_sys_i;
    bsram_host_model u_host (.clk_sys_i(clk_sys_i), .strobe_k_o(k), .strobe_k_n_o(k_n),
        .cycle_define_n_o(ld_n), .access_direction_o(dir), .addr_o(addr), .data_o(din),
        .lane_n_o(lane_n));
    bsram_port u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .strobe_k_i(k),
        .strobe_k_n_i(k_n), .cycle_define_n_i(ld_n), .access_direction_i(dir), .addr_i(addr),
        .data_i(din), .byte_write_lane_n_i(lane_n), .nibble_write_select_n_i(lane_n[1:0]),
        .data_o(dout), .data_oe_o(oe), .echo_strobe_o(echo), .echo_strobe_n_o(echo_n),
        .read_output_valid_o(vld));
    bsram_port #(.DATA_W(8), .NIBBLE(1)) u_dut_nib (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .strobe_k_i(k), .strobe_k_n_i(k_n), .cycle_define_n_i(ld_n), .access_direction_i(dir),
        .addr_i(addr), .data_i(din[7:0]), .byte_write_lane_n_i(lane_n),
        .nibble_write_select_n_i(lane_n[1:0]), .data_o(nib_dout), .data_oe_o(),
        .echo_strobe_o(), .echo_strobe_n_o(), .read_output_valid_o());
    // ========================================
    // Shared helpers
    task check(input [35:0] got, input [35:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Expected merge: lanes of width w with a set mask bit keep the old value
    function [35:0] mrg(input [35:0] o, n, input [3:0] m, input integer w);
        integer b;
        begin
            mrg = 36'h0;
            for (b = 0; b < 4 * w; b = b + 1) mrg[b] = m[b / w] ? o[b] : n[b];
        end
    endfunction
    // Reads one burst and compares both beats on both variants
    task rd_chk(input [7:0] a, input [35:0] e0, e1, n0, n1);
        integer i;
        begin
            u_host.xfer(1'b1, a, 36'h0f0f0f0f0, 36'hf0f0f0f0f, 4'hf, 4'hf);
            i = 0;
            while (vld !== 1'b1 && i < 40) begin
                @(negedge clk_sys_i);
                i = i + 1;
            end
            @(negedge clk_sys_i);
            check(vld, 1'b1);
            check(oe, 1'b1);
            check(dout, e0);
            check(nib_dout, n0);
            repeat (4) @(negedge clk_sys_i);
            check(dout, e1);
            check(nib_dout, n1);
            repeat (3) @(negedge clk_sys_i);
            check(vld, 1'b0);
            check(oe, 1'b0);
        end
    endtask
    // ========================================
    // Scenarios
    task t_idle;
        integer i, h;
        begin
            h = 0;
            for (i = 0; i < 24; i = i + 1) begin
                @(negedge clk_sys_i);
                if (oe !== 1'b0) h = h + 1;
            end
            check(h[3:0], 4'h0);
            $display("done t_idle");
        end
    endtask
    task t_echo;
        integer i, r;
        reg     p;
        begin
            r = 0;
            p = echo;
            for (i = 0; i < 32; i = i + 1) begin
                @(negedge clk_sys_i);
                check(echo ^ echo_n, 1'b1);
                if (echo && !p) r = r + 1;
                p = echo;
            end
            check(r[3:0], 4'h4);
            $display("done t_echo");
        end
    endtask
    // Second write drives the first address on its deselected half
    task t_write_read;
        begin
            u_host.xfer(1'b0, 8'hc3, 36'h9abcdef01, 36'h13579bdf0, 4'h0, 4'h0);
            u_host.xfer(1'b0, 8'h3c, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
            rd_chk(8'h3c, 36'h123456789, 36'hfedcba987, 36'h89, 36'h87);
            rd_chk(8'hc3, 36'h9abcdef01, 36'h13579bdf0, 36'h01, 36'hf0);
            $display("done t_write_read");
        end
    endtask
    // Opposite masks on the two beats catch a mask paired with the wrong beat
    task t_lane_mask;
        begin
            u_host.xfer(1'b0, 8'h3c, 36'haaaaaaaaa, 36'h555555555, 4'h5, 4'ha);
            rd_chk(8'h3c, mrg(36'h123456789, 36'haaaaaaaaa, 4'h5, 9),
                mrg(36'hfedcba987, 36'h555555555, 4'ha, 9), mrg(36'h89, 36'haa, 4'h5, 4),
                mrg(36'h87, 36'h55, 4'ha, 4));
            $display("done t_lane_mask");
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge clk_sys_i);
        check(oe, 1'b0);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        t_idle;
        t_echo;
        t_write_read;
        t_lane_mask;
        end_of_test;
    end
    // Watchdog, several times the expected run length
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
endmodule
